// ==== rtl/talk_output_formatter.sv ====
/*
 Talker output formatter: picks and serialises the text sent on each talk addressing.
 Assumes the bus front end decodes queries into one-cycle command pulses and signals
 each talk addressing with a one-cycle pulse; characters leave with valid/ready.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] After a message query, first talk gives the code, second the text.
// [RULE2] A message query clears its status bit, or after status read if SRQ active.
// [RULE3] Any function command between query and read cancels it; display returns.
// [RULE4] Hardware errors queue up to 22 entries, popped one per read.
// [RULE5] Active function string carries function code and units, at most 19 chars.
// [RULE6] Specials: -200 function off, -201 RF off, -202 reverse power tripped.
// [RULE7] One space before and one after the numeric field.
// [RULE8] Numeric field opens with a sign; leading zeros above ones digit dropped.
// [RULE9] Relative settings report the displayed relative value.
// [RULE10] Unprefixed query names active function first; none active gives display.
// [RULE11] Controller sends the function code right before the active query.
// [RULE12] Frequency: signed ten digits, fixed .0, hertz; negative when relative.
// [RULE13] Amplitude: signed ddd.d in dBm or dB; volts unsigned eight decimals. The code still sends a + sign before the volts value.
// [RULE14] Level status: +1 or HI, -1 or LO, 0 or OK.
// [RULE15] Level query: numeric on first talk, text on the next.
// [RULE16] With nothing else configured, talk returns display information.
// [RULE17] Display text first, then cursor sum, then indicator sum.
// [RULE18] Further talks repeat the three display items in order.
// [RULE19] Executing a function restarts display readout at the text.
// [RULE20] Display readout sends visible text, not a message code.
// [RULE21] Cursor n from the left weighs two to the n, from 2 to 2^25.
// [RULE22] Indicator value sums the weights of lit indicators.
module talk_output_formatter (
	input  wire logic                     CORE_CLK,
	input  wire logic                     RST_N,
	input  wire logic [7:0]               ADDR,
	input  wire logic [31:0]              WR_DATA,
	input  wire logic                     WR_EN,
	input  wire logic                     RD_EN,
	output var  logic [31:0]              RD_DATA,
	input  wire talk_fmt_pkg::cmd_type    CMD,
	input  wire logic                     TALK,
	input  wire logic                     STB_READ,
	input  wire logic                     SERVICE_REQUEST_FLAG,
	input  wire logic                     EXEC_EVENT,
	input  wire logic [15:0]              EXEC_CODE,
	input  wire logic                     CHANGE_EVENT,
	input  wire logic [15:0]              CHANGE_CODE,
	output var  talk_fmt_pkg::char_type   OUT,
	input  wire logic                     OUT_READY,
	output var  talk_fmt_pkg::status_type STAT
);
	import talk_fmt_pkg::*;

	typedef struct packed {
		logic [9:0]   ctrl;
		logic [31:0]  carrier_annunciator;
		logic [31:0]  fref;
		logic [15:0]  ampl;
		logic [15:0]  aref;
		logic [31:0]  volt;
		logic [4:0]   cursor;
		logic [23:0]  annun;
		logic [6:0]   dlen;
		logic         exec_bit;
		logic         chg_bit;
		logic         exec_pend;
		logic         chg_pend;
		logic [15:0]  exec_code;
		logic [15:0]  chg_code;
		out_mode_type mode;
		logic         msg_sel;
		logic [1:0]   phase;
		logic [1:0]   fn_pref;
		logic [1:0]   act_fn;
		seq_type      seq;
		desc_type     desc;
		logic [39:0]  rem;
		logic [3:0]   pos;
		logic [3:0]   dig;
		logic         started;
		logic [6:0]   tidx;
		logic [4:0]   hw_rd;
		logic [4:0]   hw_wr;
		logic [4:0]   hw_cnt;
		char_type     out;
		logic [31:0]  rd_data;
	} state_type;

	state_type   s_r;
	state_type   s_nxt;
	logic [7:0]  disp_mem [DISP_MAX];
	logic [15:0] hwq_mem [HWQ_DEPTH];
	logic        slot;
	logic        talk_go;
	logic        hw_push;

	// ==========================================================
	// Helpers
	function automatic logic [39:0] pow10(input logic [3:0] p);
		logic [39:0] v;
		v = 40'h1;
		for (int i = 0; i < 12; i++)
		begin
			if (i < int'(p))
			begin
				v = 40'(v * 40'ha);
			end
		end
		return v;
	endfunction : pow10

	function automatic desc_type num_desc(input logic [15:0] pre, input logic [15:0] un,
		input logic neg, input logic [39:0] mag, input logic [3:0] ndig,
		input logic [3:0] frac);
		desc_type d;
		d = '0;
		d.pre_en = 1'b1;
		d.pre = pre;
		d.sp_en = 1'b1;
		d.num_en = 1'b1;
		d.sign_en = 1'b1;
		d.neg = neg;
		d.mag = mag;
		d.ndig = ndig;
		d.frac = frac;
		d.un_en = 1'b1;
		d.un = un;
		return d;
	endfunction : num_desc

	function automatic desc_type plain_num(input logic neg, input logic [39:0] mag,
		input logic sign_en);
		desc_type d;
		d = num_desc(16'h0, 16'h0, neg, mag, 4'ha, 4'h0);
		d.pre_en = 1'b0;
		d.sp_en = 1'b0;
		d.un_en = 1'b0;
		d.sign_en = sign_en;
		return d;
	endfunction : plain_num

	function automatic desc_type active_desc(input state_type s);
		desc_type    d;
		logic [32:0] fv;
		logic [16:0] av;
		logic [15:0] code;
		logic [15:0] un;
		logic [1:0]  um;
		fv = '0;
		av = '0;
		um = s.ctrl[C_UNIT_LO +: 2];
		code = (s.act_fn == FN_CARRIER) ? S_CARRIER_CODE : S_POWER_CODE;
		un = (s.act_fn == FN_CARRIER) ? S_HZ : (um == U_VOLT) ? S_VOLT_UNITS :
			(um == U_DB) ? S_DB : S_DBM_UNITS;
		if (s.ctrl[C_FN_OFF])
		begin
			d = num_desc(code, un, 1'b1, V_FN_OFF, 4'h3, 4'h0); // [RULE6]
		end
		else if (s.act_fn == FN_POWER && s.ctrl[C_RF_OFF])
		begin
			d = num_desc(code, un, 1'b1, V_RF_OFF, 4'h3, 4'h0); // [RULE6]
		end
		else if (s.act_fn == FN_POWER && s.ctrl[C_REV_TRIP])
		begin
			d = num_desc(code, un, 1'b1, V_REV_TRIP, 4'h3, 4'h0); // [RULE6]
		end
		else if (s.act_fn == FN_CARRIER)
		begin
			// Relative mode reports the displayed offset, which may go negative
			fv = s.ctrl[C_CARRIER_ANNUNCIATOR_REL] ? 33'($signed(s.carrier_annunciator) - $signed(s.fref)) :
				{s.carrier_annunciator[31], s.carrier_annunciator}; // [RULE9]
			if (fv[32])
			begin
				fv = 33'(-$signed(fv));
				d = num_desc(code, un, 1'b1, 40'(fv * 40'ha), 4'hb, 4'h1); // [RULE12]
			end
			else
			begin
				d = num_desc(code, un, 1'b0, 40'(fv * 40'ha), 4'hb, 4'h1); // [RULE12]
			end
		end
		else if (um == U_VOLT)
		begin
			d = num_desc(code, un, 1'b0, {8'h0, s.volt}, 4'h9, 4'h8); // [RULE13]
		end
		else
		begin
			av = (um == U_DB) ? 17'($signed(s.ampl) - $signed(s.aref)) :
				{s.ampl[15], s.ampl}; // [RULE9]
			d = num_desc(code, un, av[16], {23'h0, av[16] ? 17'(-$signed(av)) : av},
				4'h4, 4'h1); // [RULE13]
		end
		return d;
	endfunction : active_desc

	// ==========================================================
	// Memories
	assign hw_push = WR_EN && ADDR == A_HW_PUSH && s_r.hw_cnt < HWQ_DEPTH_5;

	always_ff @(posedge CORE_CLK)
	begin
		if (WR_EN && ADDR == A_DISP_CHR && int'(WR_DATA[14:8]) < DISP_MAX)
		begin
			disp_mem[WR_DATA[14:8]] <= WR_DATA[7:0];
		end
		if (hw_push)
		begin
			hwq_mem[s_r.hw_wr] <= WR_DATA[15:0]; // [RULE4]
		end
	end

	// ==========================================================
	// Next state
	assign slot = !s_r.out.valid || OUT_READY;
	assign talk_go = TALK && s_r.seq == S_IDLE;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rd_data = '0;
		// Register writes
		if (WR_EN)
		begin
			if (ADDR == A_CTRL)
				s_nxt.ctrl = WR_DATA[9:0];
			else if (ADDR == A_CARRIER_ANNUNCIATOR)
				s_nxt.carrier_annunciator = WR_DATA;
			else if (ADDR == A_CARRIER_ANNUNCIATOR_REF)
				s_nxt.fref = WR_DATA;
			else if (ADDR == A_AMPL)
				s_nxt.ampl = WR_DATA[15:0];
			else if (ADDR == A_AMPL_REF)
				s_nxt.aref = WR_DATA[15:0];
			else if (ADDR == A_VOLT)
				s_nxt.volt = WR_DATA;
			else if (ADDR == A_CURSOR)
				s_nxt.cursor = WR_DATA[4:0];
			else if (ADDR == A_ANNUN)
				s_nxt.annun = WR_DATA[23:0];
			else if (ADDR == A_DISP_LEN)
				s_nxt.dlen = WR_DATA[6:0];
		end
		if (hw_push)
		begin
			s_nxt.hw_wr = (s_r.hw_wr == HWQ_DEPTH_5 - 5'h1) ? 5'h0 : 5'(s_r.hw_wr + 5'h1);
			s_nxt.hw_cnt = 5'(s_nxt.hw_cnt + 5'h1);
		end
		// Register reads, answer in the next cycle
		if (RD_EN)
		begin
			if (ADDR == A_CTRL)
				s_nxt.rd_data = {22'h0, s_r.ctrl};
			else if (ADDR == A_STATUS)
				s_nxt.rd_data = {17'h0, s_r.hw_cnt, s_r.exec_bit, s_r.chg_bit,
					s_r.exec_pend, s_r.chg_pend, s_r.phase, s_r.mode, s_r.seq != S_IDLE};
			else if (ADDR == A_CURSOR)
				s_nxt.rd_data = {27'h0, s_r.cursor};
			else if (ADDR == A_ANNUN)
				s_nxt.rd_data = {8'h0, s_r.annun};
		end
		// Deferred clears wait for the status byte read while SRQ is raised
		if (STB_READ && s_r.exec_pend)
		begin
			s_nxt.exec_bit = 1'b0; // [RULE2]
			s_nxt.exec_pend = 1'b0;
		end
		if (STB_READ && s_r.chg_pend)
		begin
			s_nxt.chg_bit = 1'b0; // [RULE2]
			s_nxt.chg_pend = 1'b0;
		end
		// Commands
		if (CMD.valid)
		begin
			s_nxt.fn_pref = FN_NONE;
			case (CMD.code)
				CMD_READ_EXEC, CMD_READ_PARAM_CHANGED:
				begin
					s_nxt.mode = M_MSG_CODE; // [RULE1]
					s_nxt.msg_sel = CMD.code == CMD_READ_PARAM_CHANGED;
					if (CMD.code == CMD_READ_EXEC && SERVICE_REQUEST_FLAG)
						s_nxt.exec_pend = 1'b1; // [RULE2]
					else if (CMD.code == CMD_READ_EXEC)
						s_nxt.exec_bit = 1'b0; // [RULE2]
					else if (SERVICE_REQUEST_FLAG)
						s_nxt.chg_pend = 1'b1; // [RULE2]
					else
						s_nxt.chg_bit = 1'b0; // [RULE2]
				end
				CMD_READ_HARDWARE_ERRORS:
					s_nxt.mode = M_HW_LIST; // [RULE4]
				CMD_READ_ACTIVE_FUNCTION:
				begin
					// A prefix only counts when it came right before the query
					s_nxt.act_fn = (s_r.fn_pref != FN_NONE) ? s_r.fn_pref :
						s_r.ctrl[C_FN_LO +: 2]; // [RULE11]
					s_nxt.mode = (s_nxt.act_fn == FN_NONE) ? M_DISPLAY : M_ACTIVE; // [RULE10]
					s_nxt.phase = 2'h0;
				end
				CMD_READ_LEVEL_STATUS:
					s_nxt.mode = M_LVL_NUM; // [RULE15]
				CMD_CARRIER_TONE_CODE, CMD_OUTPUT_POWER_CODE:
				begin
					s_nxt.fn_pref = (CMD.code == CMD_CARRIER_TONE_CODE) ? FN_CARRIER : FN_POWER;
					s_nxt.mode = M_DISPLAY; // [RULE3]
					s_nxt.phase = 2'h0; // [RULE19]
				end
				CMD_FUNC_EXEC:
				begin
					s_nxt.mode = M_DISPLAY; // [RULE3]
					s_nxt.phase = 2'h0; // [RULE19]
				end
				default:
					s_nxt.fn_pref = FN_NONE;
			endcase
		end
		// Events set after any clear so a same-cycle event is kept
		if (EXEC_EVENT)
		begin
			if (!s_r.exec_bit)
				s_nxt.exec_code = EXEC_CODE;
			s_nxt.exec_bit = 1'b1;
			s_nxt.exec_pend = 1'b0;
		end
		if (CHANGE_EVENT)
		begin
			if (!s_r.chg_bit)
				s_nxt.chg_code = CHANGE_CODE;
			s_nxt.chg_bit = 1'b1;
			s_nxt.chg_pend = 1'b0;
		end
		// Talk addressing picks the item; a talk during a message is ignored
		if (talk_go)
		begin
			s_nxt.seq = S_PRE0;
			s_nxt.tidx = '0;
			case (s_r.mode)
				M_MSG_CODE:
				begin
					s_nxt.desc = plain_num(1'b0, {24'h0, s_r.msg_sel ? s_r.chg_code :
						s_r.exec_code}, 1'b0); // [RULE1]
					s_nxt.mode = M_MSG_TEXT;
				end
				M_MSG_TEXT:
				begin
					s_nxt.desc = '0;
					s_nxt.desc.text_en = 1'b1; // [RULE1]
					s_nxt.mode = M_DISPLAY;
					s_nxt.phase = 2'h0;
				end
				M_HW_LIST:
				begin
					s_nxt.desc = plain_num(1'b0, (s_r.hw_cnt == 5'h0) ? 40'h0 :
						{24'h0, hwq_mem[s_r.hw_rd]}, 1'b0); // [RULE4]
					if (s_r.hw_cnt != 5'h0)
					begin
						s_nxt.hw_rd = (s_r.hw_rd == HWQ_DEPTH_5 - 5'h1) ? 5'h0 :
							5'(s_r.hw_rd + 5'h1);
						s_nxt.hw_cnt = 5'(s_nxt.hw_cnt - 5'h1);
					end
				end
				M_ACTIVE:
				begin
					s_nxt.desc = active_desc(s_r); // [RULE5]
					s_nxt.mode = M_DISPLAY;
					s_nxt.phase = 2'h0;
				end
				M_LVL_NUM:
				begin
					s_nxt.desc = plain_num(!s_r.ctrl[C_OVER] && s_r.ctrl[C_UNDER],
						{39'h0, s_r.ctrl[C_OVER] || s_r.ctrl[C_UNDER]},
						s_r.ctrl[C_OVER] || s_r.ctrl[C_UNDER]); // [RULE14]
					s_nxt.mode = M_LVL_TEXT; // [RULE15]
				end
				M_LVL_TEXT:
				begin
					s_nxt.desc = '0;
					s_nxt.desc.pre_en = 1'b1;
					s_nxt.desc.pre = s_r.ctrl[C_OVER] ? S_HI : s_r.ctrl[C_UNDER] ? S_LO :
						S_OK; // [RULE14]
					s_nxt.mode = M_DISPLAY;
					s_nxt.phase = 2'h0;
				end
				default:
				begin
					// Visible text is sent even while a message is shown
					s_nxt.desc = '0;
					s_nxt.desc.text_en = 1'b1; // [RULE16] [RULE17] [RULE20]
					if (s_r.phase == 2'h1)
						s_nxt.desc = plain_num(1'b0, 40'h1 << s_r.cursor, 1'b0); // [RULE21]
					else if (s_r.phase == 2'h2)
						s_nxt.desc = plain_num(1'b0, {16'h0, s_r.annun |
							((s_r.ctrl[C_FN_LO +: 2] == FN_CARRIER) ? 24'(1 << ANN_CARRIER_ANNUNCIATOR_BIT) : 24'h0) |
							((s_r.ctrl[C_FN_LO +: 2] == FN_POWER) ? 24'(1 << ANN_LEVEL_ANNUNCIATOR_BIT) : 24'h0)},
							1'b0); // [RULE22]
					s_nxt.phase = (s_r.phase == 2'h2) ? 2'h0 : 2'(s_r.phase + 2'h1); // [RULE18]
				end
			endcase
			s_nxt.rem = s_nxt.desc.mag;
			s_nxt.pos = 4'(s_nxt.desc.ndig - 4'h1);
			s_nxt.dig = '0;
			s_nxt.started = 1'b0;
		end
		// Character sequencer, stalls while the sink holds a character
		if (slot)
		begin
			s_nxt.out.valid = 1'b0;
			s_nxt.out.last = 1'b0;
			case (s_r.seq)
				S_PRE0:
				begin
					s_nxt.seq = s_r.desc.pre_en ? S_PRE1 : S_SP1;
					s_nxt.out = '{1'b1, 1'b0, s_r.desc.pre[15:8]};
					s_nxt.out.valid = s_r.desc.pre_en; // [RULE10]
				end
				S_PRE1:
				begin
					s_nxt.seq = S_SP1;
					s_nxt.out = '{1'b1, 1'b0, s_r.desc.pre[7:0]};
				end
				S_SP1:
				begin
					s_nxt.seq = s_r.desc.num_en ? S_SIGN : s_r.desc.text_en ? S_TEXT : S_END;
					s_nxt.out = '{s_r.desc.sp_en, 1'b0, CH_SP}; // [RULE7]
				end
				S_SIGN:
				begin
					s_nxt.seq = S_DIG;
					s_nxt.out = '{s_r.desc.sign_en, 1'b0,
						s_r.desc.neg ? CH_MINUS : CH_PLUS}; // [RULE8]
				end
				S_DIG:
				begin
					if (s_r.rem >= pow10(s_r.pos))
					begin
						s_nxt.rem = 40'(s_r.rem - pow10(s_r.pos));
						s_nxt.dig = 4'(s_r.dig + 4'h1);
					end
					else
					begin
						// Leading zeros above the ones digit are not sent
						s_nxt.out = '{s_r.started || s_r.dig != 4'h0 || s_r.pos <= s_r.desc.frac,
							1'b0, 8'(CH_ZERO + {4'h0, s_r.dig})}; // [RULE8]
						s_nxt.started = s_nxt.out.valid;
						s_nxt.dig = '0;
						if (s_r.pos == s_r.desc.frac && s_r.desc.frac != 4'h0)
							s_nxt.seq = S_PT;
						else if (s_r.pos == 4'h0)
							s_nxt.seq = S_SP2;
						else
							s_nxt.pos = 4'(s_r.pos - 4'h1);
					end
				end
				S_PT:
				begin
					s_nxt.out = '{1'b1, 1'b0, CH_POINT};
					s_nxt.pos = 4'(s_r.pos - 4'h1);
					s_nxt.seq = S_DIG;
				end
				S_SP2:
				begin
					s_nxt.seq = s_r.desc.un_en ? S_UN0 : S_END;
					s_nxt.out = '{s_r.desc.sp_en, 1'b0, CH_SP}; // [RULE7]
				end
				S_UN0:
				begin
					s_nxt.seq = S_UN1;
					s_nxt.out = '{1'b1, 1'b0, s_r.desc.un[15:8]}; // [RULE5]
				end
				S_UN1:
				begin
					s_nxt.seq = S_END;
					s_nxt.out = '{1'b1, 1'b0, s_r.desc.un[7:0]};
				end
				S_TEXT:
				begin
					s_nxt.out = '{s_r.tidx < s_r.dlen, 1'b0, disp_mem[s_r.tidx]};
					s_nxt.tidx = 7'(s_r.tidx + 7'h1);
					if (7'(s_r.tidx + 7'h1) >= s_r.dlen)
						s_nxt.seq = S_END;
				end
				S_END:
				begin
					s_nxt.seq = S_IDLE;
					s_nxt.out = '{1'b1, 1'b1, CH_LF};
				end
				S_IDLE:
					// Idle must keep a talk taken in this same cycle
					s_nxt.seq = talk_go ? S_PRE0 : S_IDLE;
				default:
					s_nxt.seq = S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			s_r <= '0;
			s_r.ctrl <= CTRL_RST;
			s_r.mode <= M_DISPLAY;
			s_r.seq <= S_IDLE;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	always_comb
	begin
		RD_DATA = s_r.rd_data;
		OUT = s_r.out;
		STAT = '{s_r.hw_cnt != 5'h0, s_r.exec_bit, s_r.chg_bit};
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	AST_MSG_CODE_FIRST: assert property (talk_go && s_r.mode == M_MSG_CODE |=> // [RULE1]
		s_r.mode == M_MSG_TEXT)
		else $error("message code not followed by text");
	AST_QUERY_CLEARS: assert property (CMD.valid && CMD.code == CMD_READ_EXEC && // [RULE2]
		!SERVICE_REQUEST_FLAG && !EXEC_EVENT |=> !STAT.exec_pending)
		else $error("message query did not clear status bit");
	AST_SRQ_DEFERS: assert property (SERVICE_REQUEST_FLAG && !STB_READ && // [RULE2]
		CMD.valid && CMD.code == CMD_READ_PARAM_CHANGED && STAT.change_pending |=>
		STAT.change_pending)
		else $error("bit cleared while service request flag active");
	AST_FUNC_CANCELS: assert property (CMD.valid && CMD.code == CMD_FUNC_EXEC |=> // [RULE3]
		s_r.mode == M_DISPLAY && s_r.phase == 2'h0)
		else $error("function command did not cancel pending output");
	AST_HWQ_BOUND: assert property (s_r.hw_cnt <= HWQ_DEPTH_5) // [RULE4]
		else $error("hardware error queue overflow");
	AST_SIGN_CHAR: assert property (slot && s_r.seq == S_SIGN && // [RULE8]
		s_r.desc.sign_en |=> OUT.valid && (OUT.data == CH_PLUS || OUT.data == CH_MINUS))
		else $error("numeric field without sign");
	AST_NO_ACTIVE: assert property (CMD.valid && s_r.fn_pref == FN_NONE && // [RULE10]
		CMD.code == CMD_READ_ACTIVE_FUNCTION && s_r.ctrl[C_FN_LO +: 2] == FN_NONE |=>
		s_r.mode == M_DISPLAY)
		else $error("no active function but display not selected");
	AST_LEVEL_NUM: assert property (CMD.valid && CMD.code == CMD_READ_LEVEL_STATUS |=> // [RULE15]
		s_r.mode == M_LVL_NUM)
		else $error("level query did not select numeric output");
	AST_DISPLAY_WRAP: assert property (talk_go && s_r.mode == M_DISPLAY && // [RULE18]
		s_r.phase == 2'h2 && !CMD.valid |=> s_r.phase == 2'h0)
		else $error("display readout did not wrap");
	AST_OUT_HOLD: assert property (OUT.valid && !OUT_READY |=> $stable(OUT))
		else $error("character changed while stalled");
	COV_DISPLAY_THREE: cover property (talk_go && s_r.phase == 2'h2);
	COV_HW_POP: cover property (talk_go && s_r.mode == M_HW_LIST && s_r.hw_cnt != 5'h0);
	COV_ACTIVE: cover property (talk_go && s_r.mode == M_ACTIVE);
endmodule : talk_output_formatter
`default_nettype wire

// ==== shared/talk_fmt_pkg.sv ====
/*
 Constants, types and register map for the talker-side output formatter.
 Assumes one 50 MHz core clock and a synchronous, active-low reset.
*/
`default_nettype none
package talk_fmt_pkg;
	// ==========================================================
	// Register map (byte offsets)
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_CARRIER_ANNUNCIATOR     = 8'h04;
	localparam logic [7:0] A_CARRIER_ANNUNCIATOR_REF = 8'h08;
	localparam logic [7:0] A_AMPL     = 8'h0c;
	localparam logic [7:0] A_AMPL_REF = 8'h10;
	localparam logic [7:0] A_VOLT     = 8'h14;
	localparam logic [7:0] A_CURSOR   = 8'h18;
	localparam logic [7:0] A_ANNUN    = 8'h1c;
	localparam logic [7:0] A_DISP_LEN = 8'h20;
	localparam logic [7:0] A_DISP_CHR = 8'h24;
	localparam logic [7:0] A_HW_PUSH  = 8'h28;
	localparam logic [7:0] A_STATUS   = 8'h2c;
	// ==========================================================
	// Control register fields
	localparam int C_FN_LO      = 0;
	localparam int C_UNIT_LO    = 2;
	localparam int C_RF_OFF     = 4;
	localparam int C_REV_TRIP   = 5;
	localparam int C_FN_OFF     = 6;
	localparam int C_CARRIER_ANNUNCIATOR_REL   = 7;
	localparam int C_OVER       = 8;
	localparam int C_UNDER      = 9;
	localparam logic [9:0] CTRL_RST = 10'h000;
	localparam logic [1:0] FN_NONE    = 2'h0;
	localparam logic [1:0] FN_CARRIER = 2'h1;
	localparam logic [1:0] FN_POWER   = 2'h2;
	localparam logic [1:0] U_DBM  = 2'h0;
	localparam logic [1:0] U_DB   = 2'h1;
	localparam logic [1:0] U_VOLT = 2'h2;
	// ==========================================================
	// Sizes and fixed values
	localparam int DISP_MAX  = 74;
	localparam int DISP_MIN  = 25;
	localparam int HWQ_DEPTH = 22;
	localparam logic [4:0]  HWQ_DEPTH_5 = 5'h16;
	localparam logic [39:0] V_FN_OFF    = 40'hc8;
	localparam logic [39:0] V_RF_OFF    = 40'hc9;
	localparam logic [39:0] V_REV_TRIP  = 40'hca;
	localparam int ANN_CARRIER_ANNUNCIATOR_BIT  = 5;
	localparam int ANN_LEVEL_ANNUNCIATOR_BIT = 20;
	// ==========================================================
	// Characters
	localparam logic [7:0]  CH_SP = 8'h20;
	localparam logic [7:0]  CH_PLUS = 8'h2b;
	localparam logic [7:0]  CH_MINUS = 8'h2d;
	localparam logic [7:0]  CH_POINT = 8'h2e;
	localparam logic [7:0]  CH_ZERO = 8'h30;
	localparam logic [7:0]  CH_LF = 8'h0a;
	localparam logic [15:0] S_CARRIER_CODE = 16'h4652;
	localparam logic [15:0] S_POWER_CODE = 16'h4150;
	localparam logic [15:0] S_HZ = 16'h485a;
	localparam logic [15:0] S_DBM_UNITS = 16'h444d;
	localparam logic [15:0] S_DB = 16'h4442;
	localparam logic [15:0] S_VOLT_UNITS = 16'h564c;
	localparam logic [15:0] S_HI = 16'h4849;
	localparam logic [15:0] S_LO = 16'h4c4f;
	localparam logic [15:0] S_OK = 16'h4f4b;
	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		CMD_NONE, CMD_READ_EXEC, CMD_READ_PARAM_CHANGED, CMD_READ_HARDWARE_ERRORS,
		CMD_READ_ACTIVE_FUNCTION, CMD_READ_LEVEL_STATUS, CMD_CARRIER_TONE_CODE,
		CMD_OUTPUT_POWER_CODE, CMD_FUNC_EXEC
	} cmd_code_type;
	typedef enum logic [2:0] {
		M_DISPLAY, M_MSG_CODE, M_MSG_TEXT, M_HW_LIST, M_ACTIVE, M_LVL_NUM, M_LVL_TEXT
	} out_mode_type;
	typedef enum logic [3:0] {
		S_IDLE, S_PRE0, S_PRE1, S_SP1, S_SIGN, S_DIG, S_PT, S_SP2, S_UN0, S_UN1,
		S_TEXT, S_END
	} seq_type;
	typedef struct packed {
		logic         valid;
		cmd_code_type code;
	} cmd_type;
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} char_type;
	typedef struct packed {
		logic hw_pending;
		logic exec_pending;
		logic change_pending;
	} status_type;
	typedef struct packed {
		logic        pre_en;
		logic [15:0] pre;
		logic        sp_en;
		logic        num_en;
		logic        sign_en;
		logic        neg;
		logic [39:0] mag;
		logic [3:0]  ndig;
		logic [3:0]  frac;
		logic        un_en;
		logic [15:0] un;
		logic        text_en;
	} desc_type;
endpackage : talk_fmt_pkg
`default_nettype wire

// ==== sim/ctl_model.sv ====
/*
 Bus controller stand-in: collects the talker's characters, stalling every other cycle.
 Assumes one clock shared with the formatter.
*/
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
	input  wire logic                   CORE_CLK,
	input  wire talk_fmt_pkg::char_type OUT,
	output var  logic                   OUT_READY
);
	import talk_fmt_pkg::*;
	string text = "";
	logic  done = 1'b0;
	initial OUT_READY = 1'b0;
	// Slow listener, ready only on every other cycle, so a character offered while ready is low must be held
	always @(posedge CORE_CLK)
	begin
		OUT_READY <= ~OUT_READY;
		if (OUT.valid && OUT_READY && OUT.last)
			done <= 1'b1;
		else if (OUT.valid && OUT_READY)
			text = $sformatf("%s%c", text, OUT.data);
	end
endmodule : ctl_model
`default_nettype wire

// ==== sim/instrument_talk_output_formatter_test.sv ====
/*
 Self-checking bench: register writes, commands and talk strings.
 Assumes ctl_model as the listener on the character stream.
*/
`timescale 1ns/1ps
`default_nettype none
module instrument_talk_output_formatter_test;
	import talk_fmt_pkg::*;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, tk = 0, stb = 0, srq = 0, chg = 0, rdy;
	logic        ex = 0;
	logic [7:0]  adr = 0;
	logic [31:0] wd = 0, rdat;
	cmd_type     cm = '0;
	char_type    oc;
	status_type  st;
	int          bad_count = 0, num_checks = 0;
	string       disp = "";
	string       num_s[3] = '{"+1", "-1", "0"};
	string       txt_s[3] = '{"HI", "LO", "OK"};
	logic [31:0] lvl_c[3] = '{32'h100, 32'h200, 32'h0};
	always #10 clk = ~clk;
	talk_output_formatter talk_output_formatter_inst (.CORE_CLK(clk), .RST_N(rst_n),
		.ADDR(adr), .WR_DATA(wd), .WR_EN(wr), .RD_EN(rd), .RD_DATA(rdat), .CMD(cm),
		.TALK(tk), .STB_READ(stb), .SERVICE_REQUEST_FLAG(srq), .EXEC_EVENT(ex),
		.EXEC_CODE(16'h0005), .CHANGE_EVENT(chg), .CHANGE_CODE(16'h000b), .OUT(oc),
		.OUT_READY(rdy), .STAT(st));
	ctl_model ctl_model_inst (.CORE_CLK(clk), .OUT(oc), .OUT_READY(rdy));
	task automatic chk(input string what, input string seen, input string exp);
		num_checks++;
		if (seen != exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %s seen %s", what, exp, seen);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	// Read data stand only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("read", $sformatf("%h", rdat), $sformatf("%h", exp));
	endtask : rreg
	task automatic cmd(input cmd_code_type c);
		@(posedge clk);
		cm <= '{1'b1, c};
		@(posedge clk);
		cm <= '0;
	endtask : cmd
	// Bounded wait for the terminator, listener stalling throughout
	task automatic talk(input string exp);
		int n;
		ctl_model_inst.text = "";
		ctl_model_inst.done = 1'b0;
		@(posedge clk);
		tk <= 1'b1;
		@(posedge clk);
		tk <= 1'b0;
		for (n = 0; n < 3000 && ctl_model_inst.done !== 1'b1; n++)
			@(posedge clk);
		if (n == 3000)
		begin
			bad_count++;
			close_out();
		end
		chk("talk", ctl_model_inst.text, exp);
	endtask : talk
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rreg(8'hfc, 32'h0);
		wreg(A_DISP_LEN, 32'd25);
		for (int i = 0; i < 25; i++)
		begin
			wreg(A_DISP_CHR, 32'((i << 8) | (8'h41 + i)));
			disp = $sformatf("%s%c", disp, 8'(8'h41 + i));
		end
		wreg(A_CURSOR, 32'd4);
		rreg(A_CURSOR, 32'h4);
		wreg(A_ANNUN, 32'h100020);
		talk(disp);
		talk("16");
		talk("1048608");
		talk(disp);
		cmd(CMD_FUNC_EXEC);
		talk(disp);
		$display("display test done");
		for (int i = 0; i < 3; i++)
		begin
			wreg(A_CTRL, lvl_c[i]);
			cmd(CMD_READ_LEVEL_STATUS);
			talk(num_s[i]);
			talk(txt_s[i]);
		end
		cmd(CMD_READ_LEVEL_STATUS);
		cmd(CMD_FUNC_EXEC);
		talk(disp);
		$display("level test done");
		wreg(A_CTRL, 32'h1);
		wreg(A_CARRIER_ANNUNCIATOR, 32'd100);
		cmd(CMD_READ_ACTIVE_FUNCTION);
		talk("FR +100.0 HZ");
		// Carrier stays active, so only the prefix can select power
		wreg(A_AMPL, 32'hffffff97);
		cmd(CMD_OUTPUT_POWER_CODE);
		cmd(CMD_READ_ACTIVE_FUNCTION);
		talk("AP -10.5 DM");
		wreg(A_CTRL, 32'h0);
		cmd(CMD_READ_ACTIVE_FUNCTION);
		talk(disp);
		$display("active test done");
		wreg(A_HW_PUSH, 32'd7);
		wreg(A_HW_PUSH, 32'd300);
		cmd(CMD_READ_HARDWARE_ERRORS);
		talk("7");
		talk("300");
		talk("0");
		$display("queue test done");
		ex <= 1'b1;
		@(posedge clk);
		ex <= 1'b0;
		cmd(CMD_READ_EXEC);
		#1 chk("exec", $sformatf("%b", st.exec_pending), "0");
		talk("5");
		talk(disp);
		srq <= 1'b1;
		chg <= 1'b1;
		@(posedge clk);
		chg <= 1'b0;
		cmd(CMD_READ_PARAM_CHANGED);
		#1 chk("pend", $sformatf("%b", st.change_pending), "1");
		@(posedge clk);
		stb <= 1'b1;
		@(posedge clk);
		stb <= 1'b0;
		@(posedge clk);
		#1 chk("pend", $sformatf("%b", st.change_pending), "0");
		talk("11");
		talk(disp);
		$display("message test done");
		close_out();
	end
endmodule : instrument_talk_output_formatter_test
`default_nettype wire
